//--- hw/ssd_map.svh
// Named constants of the stereo meter / sum-difference stage.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// Data widths and delay line depth
`define SSD_SW          24
`define SSD_SW1         25
`define SSD_GW          16
`define SSD_GFRAC       12
`define SSD_DW          14
`define SSD_DLY_AW      9
`define SSD_DLY_DEPTH   512
`define SSD_DLY_FRAC    4
`define SSD_MODE_W      3
`define SSD_DBW         10
`define SSD_SLW         12
`define SSD_AW          8
`define SSD_BW          32

// Register byte addresses
`define SSD_A_GAIN_L    8'h00
`define SSD_A_GAIN_R    8'h04
`define SSD_A_CTRL      8'h08
`define SSD_A_DELAY     8'h0C
`define SSD_A_SLEW      8'h10
`define SSD_A_PEAK_L    8'h14
`define SSD_A_PEAK_R    8'h18
`define SSD_A_RMS_L     8'h1C
`define SSD_A_RMS_R     8'h20
`define SSD_A_STATUS    8'h24

// Field positions, reset values, slew write limit and delay clamp
`define SSD_GAIN_OFF_BIT 16
`define SSD_INV_L_BIT    0
`define SSD_INV_R_BIT    1
`define SSD_MODE_L_LSB   2
`define SSD_MODE_R_LSB   5
`define SSD_CTRL_W       8
`define SSD_RST_GAIN     17'h01000
`define SSD_RST_CTRL     8'h20
`define SSD_RST_DELAY    14'h0000
`define SSD_RST_SLEW     12'h3E8
`define SSD_DLY_MAX      14'h1F40
`define SSD_SLEW_MAX     12'hBB8

// Output selector codes
`define SSD_M_L         3'h0
`define SSD_M_R         3'h1
`define SSD_M_SUM       3'h2
`define SSD_M_DIF       3'h3
`define SSD_M_NL        3'h4
`define SSD_M_NR        3'h5
`define SSD_M_NSUM      3'h6
`define SSD_M_RDIF      3'h7

// Timing and meter scaling
`define SSD_PEAK_MS     40
`define SSD_CLK_KHZ     20000
`define SSD_SAMPLE_HZ   48000
`define SSD_SLEW_UNITS  10
`define SSD_QDB_PER_DB  4
`define SSD_AVG_SHIFT   10
`define SSD_PK_FS       23
`define SSD_MS_FS       46
`define SSD_LGF         4
`define SSD_DB_MUL      385
`define SSD_DB_SHIFT    8
`define SSD_DB_MAX      1023
`define SSD_ACC_W       24

`endif

//--- hw/ssd_pkg.sv
// Types shared by the stereo meter stage.
// Assumes the constant header is on the include path.
`include "ssd_map.svh"
package ssd_pkg;
	typedef logic signed [`SSD_SW-1:0] ssd_smp_t;
	typedef logic [`SSD_DBW-1:0]       ssd_db_t;
	typedef enum logic [2:0] {
		SSD_IDLE,
		SSD_GAIN,
		SSD_WRITE,
		SSD_DELAY,
		SSD_MIX,
		SSD_PUSH
	} ssd_state_t;
endpackage : ssd_pkg

//--- hw/ssd_meter_if.sv
// Carrier between the stage and one of its level meters.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`include "ssd_map.svh"
interface ssd_meter_if;
	import ssd_pkg::*;
	logic                   strobe;
	logic                   tick;
	ssd_smp_t               sample;
	logic [`SSD_SLW-1:0]    slew;
	ssd_db_t                peak;
	ssd_db_t                rms;
	modport src (output strobe, output tick, output sample, output slew,
		input peak, input rms);
	modport mtr (input strobe, input tick, input sample, input slew,
		output peak, output rms);
endinterface : ssd_meter_if

//--- hw/ssd_meter.sv
// One peak and RMS level meter, readings in quarter dB below full scale.
// Assumes one strobe per sample and a tick once per update period.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_meter
	import ssd_pkg::*;
#(
	parameter int unsigned SLEW_THR = `SSD_SAMPLE_HZ * `SSD_SLEW_UNITS / `SSD_QDB_PER_DB
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	ssd_meter_if.mtr  m
);
	// Log2 in Q.4 of a value, converted to quarter dB of attenuation
	function automatic ssd_db_t to_db(input logic [47:0] v, input int fs, input logic half);
		int          p;
		int          a;
		logic [47:0] n;
		p = 0;
		for (int i = 0; i < 48; i++) begin
			if (v[i]) begin
				p = i;
			end
		end
		n = v << (47 - p);
		a = fs * 16 - (p * 16 + int'(n[46:43]));
		if (half) begin
			a = a >>> 1;
		end
		if (a < 0) begin
			a = 0;
		end
		a = (a * `SSD_DB_MUL) >>> `SSD_DB_SHIFT;
		if (v == 48'h0 || a > `SSD_DB_MAX) begin
			a = `SSD_DB_MAX;
		end
		return ssd_db_t'(a);
	endfunction : to_db

	logic [`SSD_SW-1:0]   mag;
	logic [47:0]          sq;
	logic signed [48:0]   diff;
	logic [47:0]          ms_d;
	ssd_db_t              target;
	logic [`SSD_ACC_W-1:0] acc_sum;
	logic [`SSD_SW-1:0]   max_q;
	logic [47:0]          ms_q;
	logic [`SSD_ACC_W-1:0] acc_q;
	ssd_db_t              peak_q;
	ssd_db_t              disp_q;

	// Magnitude, square, weighted average and its level
	assign mag     = m.sample[`SSD_SW-1] ? `SSD_SW'(-m.sample) : `SSD_SW'(m.sample);
	assign sq      = 48'(mag) * 48'(mag);
	assign diff    = $signed({1'b0, sq}) - $signed({1'b0, ms_q});
	assign ms_d    = 48'($signed({1'b0, ms_q}) + (diff >>> `SSD_AVG_SHIFT));
	assign target  = to_db(ms_q, `SSD_MS_FS, 1'b1);
	assign acc_sum = acc_q + `SSD_ACC_W'(m.slew);

	// Peak search restarted each period
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			max_q  <= '0;
			peak_q <= ssd_db_t'(`SSD_DB_MAX);
		end else if (m.tick) begin
			peak_q <= to_db(48'(max_q), `SSD_PK_FS, 1'b0);
			max_q  <= m.strobe ? mag : '0;
		end else if (m.strobe && mag > max_q) begin
			max_q  <= mag;
		end
	end

	// Running mean square
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ms_q <= '0;
		end else if (m.strobe) begin
			ms_q <= ms_d;
		end
	end

	// Reading moves one quarter dB each time the rate budget fills
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			acc_q  <= '0;
			disp_q <= ssd_db_t'(`SSD_DB_MAX);
		end else if (m.strobe) begin
			if (disp_q == target) begin
				acc_q <= '0;
			end else if (acc_sum >= `SSD_ACC_W'(SLEW_THR)) begin
				acc_q  <= acc_sum - `SSD_ACC_W'(SLEW_THR);
				disp_q <= (disp_q < target) ? disp_q + 1'b1 : disp_q - 1'b1;
			end else begin
				acc_q <= acc_sum;
			end
		end
	end

	assign m.peak = peak_q;
	assign m.rms  = disp_q;
endmodule : ssd_meter

//--- hw/ssd_top.sv
// Stereo gain, polarity, interchannel delay, output selection and metering.
// Assumes samples from logic on the same clock and a plain register port.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_top
	import ssd_pkg::*;
#(
	parameter int unsigned PEAK_CYCLES = `SSD_PEAK_MS * `SSD_CLK_KHZ
) (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst_b,
	input  wire logic [`SSD_AW-1:0]     i_addr,
	input  wire logic [`SSD_BW-1:0]     i_wr_data,
	input  wire logic                   i_wr_en,
	input  wire logic                   i_rd_en,
	output logic      [`SSD_BW-1:0]     o_rd_data,
	input  wire logic                   i_in_valid,
	output logic                        o_in_ready,
	input  wire logic [`SSD_SW-1:0]     i_in_l,
	input  wire logic [`SSD_SW-1:0]     i_in_r,
	output logic                        o_out_valid,
	input  wire logic                   i_out_ready,
	output logic      [`SSD_SW-1:0]     o_out_l,
	output logic      [`SSD_SW-1:0]     o_out_r
);
	// Saturate a 25-bit value into sample range
	function automatic ssd_smp_t sat(input logic signed [`SSD_SW1-1:0] v);
		if (v[`SSD_SW1-1] != v[`SSD_SW1-2]) begin
			return v[`SSD_SW1-1] ? {1'b1, {(`SSD_SW-1){1'b0}}} : {1'b0, {(`SSD_SW-1){1'b1}}};
		end
		return v[`SSD_SW-1:0];
	endfunction : sat

	// Linear gain, off and polarity of one input channel
	function automatic ssd_smp_t gain_apply(input ssd_smp_t x, input logic [`SSD_GW:0] g,
		input logic inv);
		logic signed [41:0] prod;
		logic signed [41:0] sh;
		ssd_smp_t           y;
		prod = 42'(x) * $signed({1'b0, g[`SSD_GW-1:0]});
		sh   = prod >>> `SSD_GFRAC;
		if (sh > 42'sh7FFFFF) begin
			y = 24'h7FFFFF;
		end else if (sh < -42'sh800000) begin
			y = 24'h800000;
		end else begin
			y = sh[`SSD_SW-1:0];
		end
		if (g[`SSD_GAIN_OFF_BIT]) begin
			y = '0;
		end
		return inv ? sat(-`SSD_SW1'(y)) : y;
	endfunction : gain_apply

	// Output selector
	function automatic ssd_smp_t mix(input logic [`SSD_MODE_W-1:0] md, input ssd_smp_t l,
		input ssd_smp_t r);
		logic signed [`SSD_SW1-1:0] s;
		logic signed [`SSD_SW1-1:0] d;
		s = (`SSD_SW1'(l) + `SSD_SW1'(r)) >>> 1;
		d = (`SSD_SW1'(l) - `SSD_SW1'(r)) >>> 1;
		unique case (md)
			`SSD_M_L:    return l;
			`SSD_M_R:    return r;
			`SSD_M_SUM:  return sat(s);
			`SSD_M_DIF:  return sat(d);
			`SSD_M_NL:   return sat(-`SSD_SW1'(l));
			`SSD_M_NR:   return sat(-`SSD_SW1'(r));
			`SSD_M_NSUM: return sat(-s);
			`SSD_M_RDIF: return sat(-d);
		endcase
	endfunction : mix

	ssd_state_t                 state_q;
	ssd_state_t                 state_d;
	logic [`SSD_GW:0]           gain_l_q;
	logic [`SSD_GW:0]           gain_r_q;
	logic [`SSD_CTRL_W-1:0]     ctrl_q;
	logic signed [`SSD_DW-1:0]  delay_q;
	logic [`SSD_SLW-1:0]        slew_q;
	ssd_smp_t                   in_l_q;
	ssd_smp_t                   in_r_q;
	ssd_smp_t                   g_l_q;
	ssd_smp_t                   g_r_q;
	ssd_smp_t                   d_l_q;
	ssd_smp_t                   d_r_q;
	ssd_smp_t                   mix_q [2];
	ssd_smp_t                   dl_l [`SSD_DLY_DEPTH];
	ssd_smp_t                   dl_r [`SSD_DLY_DEPTH];
	logic [`SSD_DLY_AW-1:0]     wp_q;
	ssd_smp_t                   spare_l_q;
	ssd_smp_t                   spare_r_q;
	logic [1:0]                 cnt_q;
	logic [31:0]                per_q;
	logic                       tick_q;
	logic                       strobe_q;
	ssd_db_t                    peak [2];
	ssd_db_t                    rms [2];

	// Register decode
	wire take      = i_in_valid & o_in_ready;
	wire we_gain_l = i_wr_en & (i_addr == `SSD_A_GAIN_L);
	wire we_gain_r = i_wr_en & (i_addr == `SSD_A_GAIN_R);
	wire we_ctrl   = i_wr_en & (i_addr == `SSD_A_CTRL);
	wire we_delay  = i_wr_en & (i_addr == `SSD_A_DELAY);
	wire we_slew   = i_wr_en & (i_addr == `SSD_A_SLEW);
	wire [`SSD_SLW-1:0] slew_wr = (i_wr_data[`SSD_SLW-1:0] > `SSD_SLEW_MAX) ?
		`SSD_SLEW_MAX : i_wr_data[`SSD_SLW-1:0];

	// Delay split into whole samples and sixteenths
	wire                     dly_neg = delay_q[`SSD_DW-1];
	wire [`SSD_DW-1:0]       dly_abs = dly_neg ? `SSD_DW'(-delay_q) : `SSD_DW'(delay_q);
	wire [`SSD_DW-1:0]       dly_mag = (dly_abs > `SSD_DLY_MAX) ? `SSD_DLY_MAX : dly_abs;
	wire [`SSD_DLY_AW-1:0]   dly_n   = dly_mag[`SSD_DW-2:`SSD_DLY_FRAC];
	wire [`SSD_DLY_FRAC-1:0] dly_f   = dly_mag[`SSD_DLY_FRAC-1:0];
	wire [`SSD_DLY_AW-1:0]   ra      = wp_q - dly_n;
	wire [`SSD_DLY_AW-1:0]   rb      = ra - 1'b1;
	wire ssd_smp_t           ta      = dly_neg ? dl_r[ra] : dl_l[ra];
	wire ssd_smp_t           tb      = dly_neg ? dl_r[rb] : dl_l[rb];
	wire signed [`SSD_SW1-1:0] tstep = `SSD_SW1'(tb) - `SSD_SW1'(ta);
	wire signed [30:0]       tprod   = 31'(tstep) * $signed({1'b0, dly_f});
	wire ssd_smp_t           tap     = `SSD_SW'(31'(ta) + (tprod >>> `SSD_DLY_FRAC));

	// Output buffer handshake
	wire can_push = (state_q == SSD_PUSH) & (cnt_q != 2'h2);
	wire pop      = o_out_valid & i_out_ready;

	// Read data mux
	wire [`SSD_BW-1:0] rd_mux =
		(i_addr == `SSD_A_GAIN_L) ? `SSD_BW'(gain_l_q) :
		(i_addr == `SSD_A_GAIN_R) ? `SSD_BW'(gain_r_q) :
		(i_addr == `SSD_A_CTRL)   ? `SSD_BW'(ctrl_q) :
		(i_addr == `SSD_A_DELAY)  ? `SSD_BW'($unsigned(delay_q)) :
		(i_addr == `SSD_A_SLEW)   ? `SSD_BW'(slew_q) :
		(i_addr == `SSD_A_PEAK_L) ? `SSD_BW'(peak[0]) :
		(i_addr == `SSD_A_PEAK_R) ? `SSD_BW'(peak[1]) :
		(i_addr == `SSD_A_RMS_L)  ? `SSD_BW'(rms[0]) :
		(i_addr == `SSD_A_RMS_R)  ? `SSD_BW'(rms[1]) :
		(i_addr == `SSD_A_STATUS) ? `SSD_BW'(cnt_q) : '0;

	// Software settings
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			gain_l_q <= `SSD_RST_GAIN;
			gain_r_q <= `SSD_RST_GAIN;
			ctrl_q   <= `SSD_RST_CTRL;
			delay_q  <= `SSD_RST_DELAY;
			slew_q   <= `SSD_RST_SLEW;
		end else begin
			if (we_gain_l) gain_l_q <= i_wr_data[`SSD_GW:0];
			if (we_gain_r) gain_r_q <= i_wr_data[`SSD_GW:0];
			if (we_ctrl)   ctrl_q   <= i_wr_data[`SSD_CTRL_W-1:0];
			if (we_delay)  delay_q  <= i_wr_data[`SSD_DW-1:0];
			if (we_slew)   slew_q   <= slew_wr;
		end
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data <= i_rd_en ? rd_mux : '0;
		end
	end

	// Sample sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SSD_IDLE:  if (take) state_d = SSD_GAIN;
			SSD_GAIN:  state_d = SSD_WRITE;
			SSD_WRITE: state_d = SSD_DELAY;
			SSD_DELAY: state_d = SSD_MIX;
			SSD_MIX:   state_d = SSD_PUSH;
			SSD_PUSH:  if (can_push) state_d = SSD_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state_q    <= SSD_IDLE;
			o_in_ready <= 1'b0;
		end else begin
			state_q    <= state_d;
			o_in_ready <= (state_d == SSD_IDLE);
		end
	end

	// Capture, gain and polarity per channel
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			in_l_q <= '0;
			in_r_q <= '0;
			g_l_q  <= '0;
			g_r_q  <= '0;
		end else if (take) begin
			in_l_q <= i_in_l;
			in_r_q <= i_in_r;
		end else if (state_q == SSD_GAIN) begin
			g_l_q <= gain_apply(in_l_q, gain_l_q, ctrl_q[`SSD_INV_L_BIT]);
			g_r_q <= gain_apply(in_r_q, gain_r_q, ctrl_q[`SSD_INV_R_BIT]);
		end
	end

	// Delay lines hold recent gained samples of both channels
	always_ff @(posedge i_sys_clk) begin
		if (state_q == SSD_WRITE) begin
			dl_l[wp_q] <= g_l_q;
			dl_r[wp_q] <= g_r_q;
		end
	end

	// Only the channel named by the sign takes the delayed tap
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			wp_q  <= '0;
			d_l_q <= '0;
			d_r_q <= '0;
		end else if (state_q == SSD_DELAY) begin
			wp_q  <= wp_q + 1'b1;
			d_l_q <= (!dly_neg && delay_q != '0) ? tap : g_l_q;
			d_r_q <= dly_neg ? tap : g_r_q;
		end
	end

	// Selector per side, after polarity and delay
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			mix_q[0] <= '0;
			mix_q[1] <= '0;
		end else if (state_q == SSD_MIX) begin
			mix_q[0] <= mix(ctrl_q[`SSD_MODE_L_LSB +: `SSD_MODE_W], d_l_q, d_r_q);
			mix_q[1] <= mix(ctrl_q[`SSD_MODE_R_LSB +: `SSD_MODE_W], d_l_q, d_r_q);
		end
	end

	// Two-entry output buffer: head drives the port, spare absorbs a stall
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			cnt_q       <= '0;
			o_out_valid <= 1'b0;
			o_out_l     <= '0;
			o_out_r     <= '0;
			spare_l_q   <= '0;
			spare_r_q   <= '0;
		end else begin
			if (can_push && (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))) begin
				o_out_l <= mix_q[0];
				o_out_r <= mix_q[1];
			end else if (pop && cnt_q == 2'h2) begin
				o_out_l <= spare_l_q;
				o_out_r <= spare_r_q;
			end
			if (can_push && cnt_q == 2'h1 && !pop) begin
				spare_l_q <= mix_q[0];
				spare_r_q <= mix_q[1];
			end
			if (can_push && !pop) begin
				cnt_q       <= cnt_q + 1'b1;
				o_out_valid <= 1'b1;
			end else if (pop && !can_push) begin
				cnt_q       <= cnt_q - 1'b1;
				o_out_valid <= (cnt_q == 2'h2);
			end
		end
	end

	// Meter update period and per-sample strobe
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			per_q    <= '0;
			tick_q   <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			per_q    <= (per_q == PEAK_CYCLES - 1) ? '0 : per_q + 1'b1;
			tick_q   <= (per_q == PEAK_CYCLES - 1);
			strobe_q <= can_push;
		end
	end

	// One meter pair per output side, fed with the output signal itself
	for (genvar s = 0; s < 2; s++) begin : g_meter
		ssd_meter_if mi ();
		assign mi.strobe = strobe_q;
		assign mi.tick   = tick_q;
		assign mi.sample = mix_q[s];
		assign mi.slew   = slew_q;
		assign peak[s]   = mi.peak;
		assign rms[s]    = mi.rms;
		ssd_meter u_meter (
			.i_sys_clk (i_sys_clk),
			.i_rst_b   (i_rst_b),
			.m         (mi.mtr)
		);
	end
endmodule : ssd_top

//--- bench/ssd_top_checker.sv
// Port-level timing checks of the stereo meter stage.
// Assumes it is bound onto ssd_top and sees only its ports.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_top_checker #(
	parameter int unsigned PEAK_CYCLES = 64
) (
	input wire logic               i_sys_clk,
	input wire logic               i_rst_b,
	input wire logic [`SSD_AW-1:0] i_addr,
	input wire logic [`SSD_BW-1:0] i_wr_data,
	input wire logic               i_wr_en,
	input wire logic               i_rd_en,
	input wire logic [`SSD_BW-1:0] o_rd_data,
	input wire logic               i_in_valid,
	input wire logic               o_in_ready,
	input wire logic [`SSD_SW-1:0] i_in_l,
	input wire logic [`SSD_SW-1:0] i_in_r,
	input wire logic               o_out_valid,
	input wire logic               i_out_ready,
	input wire logic [`SSD_SW-1:0] o_out_l,
	input wire logic [`SSD_SW-1:0] o_out_r
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	// Handshake decodes
	wire take_w = i_in_valid && o_in_ready;
	wire pop_w  = o_out_valid && i_out_ready;
	rd_quiet_a: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
		else $error("read data not zero outside a read answer");
	in_gap_a: assert property (take_w |=> !o_in_ready [*5])
		else $error("input ready too soon after a take");
	in_wait_a: assert property (o_in_ready && !i_in_valid |=> o_in_ready)
		else $error("input ready dropped while idle");
	out_hold_a: assert property (o_out_valid && !i_out_ready |=>
		o_out_valid && $stable(o_out_l) && $stable(o_out_r))
		else $error("output changed while stalled");
	out_early_a: assert property (take_w && !o_out_valid |=> !o_out_valid [*5])
		else $error("output valid before the pipeline finished");
	out_time_a: assert property (take_w && !o_out_valid |-> ##6 o_out_valid)
		else $error("output not shown six cycles after take");
	valid_fall_a: assert property ($fell(o_out_valid) |-> $past(i_out_ready))
		else $error("output valid fell without a pop");
	data_move_a: assert property ($changed(o_out_r) && $past(o_out_valid)
		|-> $past(pop_w))
		else $error("output data moved without a pop");
	cover property (take_w && !i_out_ready);
	cover property (o_out_valid && !i_out_ready ##1 pop_w);
	cover property ($past(i_rd_en) && o_rd_data != '0);
endmodule : ssd_top_checker

bind ssd_top ssd_top_checker #(.PEAK_CYCLES(PEAK_CYCLES)) chk (.i_sys_clk(i_sys_clk),
	.i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
	.i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_in_valid(i_in_valid),
	.o_in_ready(o_in_ready), .i_in_l(i_in_l), .i_in_r(i_in_r),
	.o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_l(o_out_l),
	.o_out_r(o_out_r));

//--- bench/ssd_stream_model.sv
// Upstream sample source and downstream sink around the stage.
// Assumes one clock; the bench calls send and reads the got queues.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_stream_model (
	input  wire logic               i_sys_clk,
	input  wire logic               i_stall,
	input  wire logic               i_in_ready,
	input  wire logic               i_out_valid,
	input  wire logic [`SSD_SW-1:0] i_out_l,
	input  wire logic [`SSD_SW-1:0] i_out_r,
	output logic                    o_in_valid,
	output logic      [`SSD_SW-1:0] o_in_l,
	output logic      [`SSD_SW-1:0] o_in_r,
	output logic                    o_out_ready
);
	logic [`SSD_SW-1:0] got_l[$];
	logic [`SSD_SW-1:0] got_r[$];
	initial begin
		o_in_valid = 1'b0;
		o_in_l = '0;
		o_in_r = '0;
	end
	// Offer a pair, hold it until taken, then scramble the released lines
	task automatic send(input logic [`SSD_SW-1:0] l, input logic [`SSD_SW-1:0] r);
		@(posedge i_sys_clk);
		o_in_valid <= 1'b1;
		o_in_l <= l;
		o_in_r <= r;
		do @(posedge i_sys_clk); while (i_in_ready !== 1'b1);
		o_in_valid <= 1'b0;
		o_in_l <= ~l;
		o_in_r <= ~r;
	endtask : send
	// Sink: record every popped pair, stall on request
	always @(posedge i_sys_clk) begin
		if (i_out_valid === 1'b1 && o_out_ready === 1'b1) begin
			got_l.push_back(i_out_l);
			got_r.push_back(i_out_r);
		end
		o_out_ready <= !i_stall;
	end
endmodule : ssd_stream_model

//--- bench/ssd_top_tb.sv
// Self-checking bench of the stereo meter stage.
// Assumes the stream model as far side and a short peak period.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_top_tb;
	logic        clk, rst_b, wr_en, rd_en, stall, in_valid, in_ready, out_valid, out_ready;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d, q;
	logic [23:0] in_l, in_r, out_l, out_r;
	int          mismatches, checks_done, i;
	logic [7:0]  ta[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28};
	logic [31:0] te[9] = '{32'h1000, 32'h1000, 32'h20, 32'h0, 32'h3E8, 32'h3FF, 32'h3FF,
		32'h0, 32'h0};
	ssd_top #(.PEAK_CYCLES(64)) dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
		.i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rdata),
		.i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_l(in_l), .i_in_r(in_r),
		.o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_l(out_l), .o_out_r(out_r));
	ssd_stream_model p (.i_sys_clk(clk), .i_stall(stall), .i_in_ready(in_ready),
		.i_out_valid(out_valid), .i_out_l(out_l), .i_out_r(out_r), .o_in_valid(in_valid),
		.o_in_l(in_l), .o_in_r(in_r), .o_out_ready(out_ready));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic finish_test;
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Register port: one-cycle strobes, read data the cycle after
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a, d);
		chk(nm, e, d);
	endtask : rd_chk
	// Wait for one popped pair and compare it
	task automatic pop_chk(input int el, input int er);
		for (int n = 0; n < 100 && p.got_l.size() == 0; n++) @(posedge clk);
		if (p.got_l.size() == 0) begin
			chk("out pair present", 1, 0);
			return;
		end
		chk("out_l", el[23:0], p.got_l.pop_front());
		chk("out_r", er[23:0], p.got_r.pop_front());
	endtask : pop_chk
	task automatic xfer(input int l, input int r, input int el, input int er);
		p.send(l[23:0], r[23:0]);
		pop_chk(el, er);
	endtask : xfer
	function automatic int mix(input logic [2:0] m, input int a, input int b);
		case (m)
			`SSD_M_L:    return a;
			`SSD_M_R:    return b;
			`SSD_M_SUM:  return (a + b) >>> 1;
			`SSD_M_DIF:  return (a - b) >>> 1;
			`SSD_M_NL:   return -a;
			`SSD_M_NR:   return -b;
			`SSD_M_NSUM: return -((a + b) >>> 1);
			default:     return (b - a) >>> 1;
		endcase
	endfunction : mix
	function automatic logic [31:0] cw(input int ml, input int mr, input int inv);
		return (mr << `SSD_MODE_R_LSB) | (ml << `SSD_MODE_L_LSB) | inv;
	endfunction : cw
	// Watchdog well beyond the expected run
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		finish_test();
	end
	initial begin
		rst_b = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		stall = 1'b0;
		addr = '0;
		wdata = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 9; i++) rd_chk("reset value", ta[i], te[i]);
		wr(`SSD_A_PEAK_L, 32'h0);
		rd_chk("peak_l read only", `SSD_A_PEAK_L, 32'h3FF);
		wr(`SSD_A_SLEW, 32'hFFF);
		rd_chk("slew clamp", `SSD_A_SLEW, 32'hBB8);
		// Every selector code on each side
		for (i = 0; i < 8; i++) begin
			wr(`SSD_A_CTRL, cw(i, 7 - i, 0));
			xfer(1000, -600, mix(i, 1000, -600), mix(7 - i, 1000, -600));
		end
		wr(`SSD_A_CTRL, cw(2, 3, 1));
		xfer(1000, -600, -800, -200);
		wr(`SSD_A_GAIN_L, 32'h2000);
		wr(`SSD_A_GAIN_R, 32'h11000);
		wr(`SSD_A_CTRL, cw(0, 2, 0));
		xfer(1000, -600, 2000, 1000);
		wr(`SSD_A_GAIN_L, 32'h1000);
		wr(`SSD_A_GAIN_R, 32'h1000);
		// Whole, fractional and negative interchannel delay
		wr(`SSD_A_CTRL, cw(0, 1, 0));
		wr(`SSD_A_DELAY, 32'h10);
		xfer(100, 7, 2000, 7);
		xfer(200, 8, 100, 8);
		wr(`SSD_A_DELAY, 32'h8);
		xfer(600, 9, 400, 9);
		wr(`SSD_A_DELAY, 32'h3FF0);
		rd_chk("delay readback", `SSD_A_DELAY, 32'h3FF0);
		xfer(700, 20, 700, 9);
		xfer(800, 30, 800, 20);
		wr(`SSD_A_DELAY, 32'h0);
		// Fill the output buffer while the sink stalls
		@(posedge clk);
		stall <= 1'b1;
		p.send(24'h11, 24'h21);
		p.send(24'h12, 24'h22);
		repeat (8) @(posedge clk);
		rd_chk("status full", `SSD_A_STATUS, 32'h2);
		fork
			p.send(24'h13, 24'h23);
		join_none
		repeat (20) @(posedge clk);
		chk("refused while full", 32'h0, {31'h0, in_ready});
		stall <= 1'b0;
		for (i = 1; i < 4; i++) pop_chk(16 + i, 32 + i);
		wait fork;
		// Second reset clears meter history before the level checks
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk("ctrl after reset", `SSD_A_CTRL, 32'h20);
		// Meters follow the selected outputs
		wr(`SSD_A_SLEW, 32'hBB8);
		repeat (100) xfer(24'h400000, 0, 24'h400000, 0);
		rd(`SSD_A_PEAK_L, d);
		chk("peak_l near 6 dB", 1, d >= 21 && d <= 27);
		rd_chk("peak_r silent", `SSD_A_PEAK_R, 32'h3FF);
		rd_chk("rms_r silent", `SSD_A_RMS_R, 32'h3FF);
		rd(`SSD_A_RMS_L, d);
		chk("rms_l rising", 1, d < 32'h3FF && d > 32'h3F0);
		wr(`SSD_A_SLEW, 32'h0);
		repeat (50) xfer(0, 0, 0, 0);
		rd_chk("rms_l frozen", `SSD_A_RMS_L, d);
		rd_chk("peak_l restarted", `SSD_A_PEAK_L, 32'h3FF);
		finish_test();
	end
endmodule : ssd_top_tb
